// ===== common/diag_pkg.sv
// constants shared by the diagnostic image block and its output filter
package diag_pkg;
   // register byte offsets on the apb side
   localparam logic [7:0] OFF_GEN    = 8'h00;
   localparam logic [7:0] OFF_SNS    = 8'h04;
   localparam logic [7:0] OFF_ACT    = 8'h08;
   localparam logic [7:0] OFF_CFG    = 8'h0c;
   localparam logic [7:0] OFF_VVEN   = 8'h10;
   localparam logic [7:0] OFF_VDEV   = 8'h14;
   localparam logic [7:0] OFF_VEN    = 8'h18;
   localparam logic [7:0] OFF_PORT   = 8'h1c;
   localparam logic [7:0] OFF_IRQ_ST = 8'h20;
   localparam logic [7:0] OFF_IRQ_CL = 8'h24;
   localparam logic [7:0] OFF_IRQ_EN = 8'h28;
   // config register fields
   localparam int CFG_AUX_EN  = 0;
   localparam int CFG_DOF_EN  = 1;
   localparam int CFG_TMO_LSB = 8;
   localparam logic [15:0] CFG_RST = 16'h5001;
   localparam logic [7:0]  TMO_RST = 8'h50;
   // general diagnostic word bit positions
   localparam int GEN_SYS_LV = 0;
   localparam int GEN_AUX_LV = 1;
   localparam int GEN_SNS_SC = 2;
   localparam int GEN_ACT_SC = 3;
   localparam int GEN_SUM0   = 8;
   // interrupt event bit positions
   localparam int EV_SYS = 0;
   localparam int EV_AUX = 1;
   localparam int EV_SNS = 2;
   localparam int EV_ACT = 3;
   localparam int EV_VAL = 4;
   localparam int EV_W   = 5;
   // timing
   localparam int CLK_NS    = 100;
   localparam int MS_NS     = 1000000;
   localparam int CYC_MS    = MS_NS / CLK_NS;
   localparam int FILTER_MS = 5;
endpackage

// ===== common/chan_if.sv
// carrier between the image block and the output channel filter
`timescale 1ns/1ps
interface chan_if #(parameter int N = 16);
   logic [N-1:0] cmd;        // commanded channel values
   logic [N-1:0] rb;         // read-back physical values
   logic [N-1:0] err;        // filtered channel errors
   logic         ms_tick;    // one-cycle pulse every millisecond
   logic [7:0]   timeout_ms; // surveillance mask after switch-on
   modport ctl (output cmd, rb, ms_tick, timeout_ms, input err);
   modport filt (input cmd, rb, ms_tick, timeout_ms, output err);
endinterface

// ===== design/chan_filter.sv
// per-channel mismatch filter with switch-on surveillance mask
`timescale 1ns/1ps
module chan_filter
   import diag_pkg::*;
#(
   parameter int N = 16
)(
   input  wire logic clk_i,    // system clock
   input  wire logic arst_n_i, // async reset, active low
   chan_if.filt      ch        // channel values and filtered errors
);
   logic [N-1:0] cmd_d_ff; // previous command, for edge detect

   // remember last command to spot switch-on
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
         cmd_d_ff <= '0;
      else
         cmd_d_ff <= ch.cmd;

   for (genvar i = 0; i < N; i++)
   begin : g_ch
      logic [7:0] mask_ff;  // remaining mask time in ms
      logic [2:0] pers_ff;  // ms the mismatch has persisted
      logic       err_ff;   // filtered error level
      logic       rise;     // switch-on edge
      logic       mism;     // command and read-back differ
      assign rise = ch.cmd[i] & ~cmd_d_ff[i];
      assign mism = ch.cmd[i] ^ ch.rb[i];

      // surveillance mask reloads on every switch-on
      always_ff @(posedge clk_i or negedge arst_n_i)
         if (!arst_n_i)
            mask_ff <= '0;
         else if (rise)
            mask_ff <= ch.timeout_ms;
         else if (ch.ms_tick && mask_ff != 8'h00)
            mask_ff <= mask_ff - 8'h01;

      // persistence filter; clears itself when the mismatch goes
      always_ff @(posedge clk_i or negedge arst_n_i)
         if (!arst_n_i)
         begin
            pers_ff <= '0;
            err_ff  <= 1'b0;
         end
         else if (rise || !mism || mask_ff != 8'h00)
         begin
            pers_ff <= '0;
            err_ff  <= 1'b0;
         end
         else if (ch.ms_tick && pers_ff != 3'(FILTER_MS))
            pers_ff <= pers_ff + 3'h1;
         else if (pers_ff == 3'(FILTER_MS))
            err_ff <= 1'b1;
      assign ch.err[i] = err_ff;
   end

   // channel 0 is masked right after switch-on
   AST_MASK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (ch.cmd[0] && !cmd_d_ff[0]) |=> !ch.err[0])
      else $error("channel error not masked after switch-on");
endmodule

// ===== design/diag_image.sv
// diagnostic image builder: supplies, shorts, channel errors, port status
`timescale 1ns/1ps
// Contract
// - system supply out of range sets flag
// - system fault only darkens green indicator
// - general byte 0 flag order fixed
// - general byte 1 summaries, upper nibble zero
// - aux flag and red only when enabled
// - aux reporting off suppresses aux diagnostics
// - aux failure flags commanded-high channels
// - actuator bytes map channels one to sixteen
// - sensor short sets flag and port bit
// - output short sets flag and channel bit
// - channel error is command/read-back mismatch
// - switch-on masks errors for surveillance timeout
// - steady-on error reported after filter delay
// - id mismatch sets port validation error
// - separate per-port error, warning, notice bits
module diag_image
   import diag_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_MS, // clock cycles per millisecond
   parameter int NCH        = 16      // output channels
)(
   input  wire logic              clk_i,           // system clock
   input  wire logic              arst_n_i,        // async reset, low
   input  wire logic              psel_i,          // apb select
   input  wire logic              penable_i,       // apb enable
   input  wire logic              pwrite_i,        // apb write
   input  wire logic [7:0]        paddr_i,         // apb byte address
   input  wire logic [31:0]       pwdata_i,        // apb write data
   output logic [31:0]            prdata_o,        // apb read data
   output logic                   pready_o,        // apb ready
   output logic                   pslverr_o,       // apb error
   input  wire logic              sys_uv_i,        // system supply < 18 V
   input  wire logic              sys_ov_i,        // system supply > 30 V
   input  wire logic              aux_uv_i,        // aux supply < 18 V
   input  wire logic              aux_ov_i,        // aux supply > 30 V
   input  wire logic              temp_over_i,     // over temperature
   input  wire logic              temp_under_i,    // under temperature
   input  wire logic              fw_err_i,        // firmware error
   input  wire logic              int_err_i,       // internal module error
   input  wire logic [7:0]        sns_short_i,     // sensor supply shorts
   input  wire logic [NCH-1:0]    out_short_i,     // output shorts
   input  wire logic [NCH-1:0]    out_cmd_i,       // commanded outputs
   input  wire logic [NCH-1:0]    out_rb_i,        // read-back outputs
   input  wire logic              id_stb_i,        // port ids valid pulse
   input  wire logic [2:0]        port_index_i,    // port of the ids
   input  wire logic [15:0]       id_vendor_i,     // reported vendor id
   input  wire logic [23:0]       id_device_i,     // reported device id
   input  wire logic [7:0]        dev_err_i,       // port device errors
   input  wire logic [7:0]        dev_warn_i,      // port device warnings
   input  wire logic [7:0]        dev_notice_i,    // port notifications
   output logic [15:0]            gen_diag_o,      // general diag word
   output logic [15:0]            sensor_diag_o,   // sensor diag word
   output logic [NCH-1:0]         act_diag_o,      // actuator diag word
   output logic                   sys_led_green_o, // system supply ok
   output logic                   aux_led_red_o,   // aux supply fault
   output logic                   irq_o            // interrupt, high
);
   localparam int TW = $clog2(CYC_PER_MS + 1);

   chan_if #(.N(NCH)) ch ();               // link to the filter

   logic [TW-1:0]    tick_cnt_ff;           // millisecond prescaler
   logic             tick_ff;               // millisecond pulse
   logic [15:0]      cfg_ff;                // options and timeout
   logic [15:0]      vvendor_ff;            // expected vendor id
   logic [23:0]      vdevice_ff;            // expected device id
   logic [7:0]       val_en_ff;             // validate per port
   logic [EV_W-1:0]  irq_en_ff;             // interrupt enables
   logic [EV_W-1:0]  irq_st_ff;             // sticky events
   logic             irq_ff;                // interrupt output
   logic [15:0]      gen_ff;                // general diag word
   logic [15:0]      sns_ff;                // sensor diag word
   logic [NCH-1:0]   act_ff;                // actuator diag word
   logic [7:0]       val_err_ff;            // validation errors
   logic [7:0]       deverr_ff;             // device errors
   logic [7:0]       devwarn_ff;            // device warnings
   logic [7:0]       devnote_ff;            // device notices
   logic             led_g_ff;              // green indicator
   logic             led_r_ff;              // red indicator
   logic             pready_ff;             // apb ready
   logic             pslverr_ff;            // apb error
   logic [31:0]      prdata_ff;             // apb read data
   logic [15:0]      nxt_gen;               // next general word
   logic [NCH-1:0]   nxt_act;               // next actuator word
   logic [7:0]       nxt_val;               // next validation bits
   logic [EV_W-1:0]  ev;                    // new events
   logic             sys_flt;               // system supply fault
   logic             aux_flt;               // aux supply fault
   logic             aux_rep;               // aux reporting enabled
   logic             acc;                   // apb access phase
   logic             wr;                    // write takes effect
   logic [31:0]      rd_mux;                // read data select
   logic             mapped;                // address decodes

   // write strobe for one register offset
   function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                   input logic [7:0] off);
      wr_hit = w && (a == off);
   endfunction

   assign sys_flt = sys_uv_i | sys_ov_i;
   assign aux_flt = aux_uv_i | aux_ov_i;
   assign aux_rep = cfg_ff[CFG_AUX_EN];
   assign acc     = psel_i & penable_i;
   assign wr      = acc & pready_ff & pwrite_i;

   // filter hookup
   assign ch.cmd        = out_cmd_i;
   assign ch.rb         = out_rb_i;
   assign ch.ms_tick    = tick_ff;
   assign ch.timeout_ms = cfg_ff[CFG_TMO_LSB +: 8];

   chan_filter #(.N(NCH)) u_filt (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ch       (ch)
   );

   // millisecond prescaler for the filter and the mask
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end
      else if (tick_cnt_ff == TW'(CYC_PER_MS - 1))
      begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b1;
      end
      else
      begin
         tick_cnt_ff <= tick_cnt_ff + TW'(1);
         tick_ff     <= 1'b0;
      end

   // next diagnostic image, from present conditions and held port, validation and filter state
   always_comb
   begin
      nxt_gen = '0;
      nxt_gen[GEN_SYS_LV] = sys_flt;
      nxt_gen[GEN_AUX_LV] = aux_flt & aux_rep;
      nxt_gen[GEN_SNS_SC] = |sns_short_i;
      nxt_gen[GEN_ACT_SC] = |out_short_i;
      nxt_gen[4] = temp_under_i;
      nxt_gen[5] = temp_over_i;
      nxt_gen[6] = fw_err_i;
      nxt_gen[7] = int_err_i;
      // summaries lag the per-port bits by one cycle
      nxt_gen[GEN_SUM0 +: 4] = {|devnote_ff, |devwarn_ff,
                                |deverr_ff, |val_err_ff};
      // readback is meaningless without aux supply, so only the
      // opt-in commanded-high report stands in for the filter then
      if (aux_flt)
         nxt_act = out_short_i |
                   ((aux_rep && cfg_ff[CFG_DOF_EN]) ? out_cmd_i
                                                    : '0);
      else
         nxt_act = out_short_i | ch.err;
      // validation bits drop as soon as a port stops being checked
      nxt_val = val_err_ff & val_en_ff;
      if (id_stb_i)
         nxt_val[port_index_i] = val_en_ff[port_index_i] &&
            (id_vendor_i != vvendor_ff ||
             id_device_i != vdevice_ff);
   end

   // rising edges of reported supply, short, channel and validation faults are interrupt events
   always_comb
   begin
      ev = '0;
      ev[EV_SYS] = nxt_gen[GEN_SYS_LV] & ~gen_ff[GEN_SYS_LV];
      ev[EV_AUX] = nxt_gen[GEN_AUX_LV] & ~gen_ff[GEN_AUX_LV];
      ev[EV_SNS] = |(sns_short_i & ~sns_ff[7:0]);
      ev[EV_ACT] = |(nxt_act & ~act_ff);
      ev[EV_VAL] = |(nxt_val & ~val_err_ff);
   end

   // diagnostic image follows the conditions level by level
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         gen_ff <= '0;
         sns_ff <= '0;
         act_ff <= '0;
      end
      else
      begin
         gen_ff <= nxt_gen;
         sns_ff <= {8'h00, sns_short_i};
         act_ff <= nxt_act;
      end

   // per-port status, kept per severity
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         val_err_ff <= '0;
         deverr_ff  <= '0;
         devwarn_ff <= '0;
         devnote_ff <= '0;
      end
      else
      begin
         val_err_ff <= nxt_val;
         deverr_ff  <= dev_err_i;
         devwarn_ff <= dev_warn_i;
         devnote_ff <= dev_notice_i;
      end

   // supply indicators; supply faults also reach the general diag word, and an aux fault the actuator word
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         led_g_ff <= 1'b0;
         led_r_ff <= 1'b0;
      end
      else
      begin
         led_g_ff <= ~sys_flt;
         led_r_ff <= aux_flt & aux_rep;
      end

   // software configuration registers
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         cfg_ff     <= CFG_RST;
         vvendor_ff <= '0;
         vdevice_ff <= '0;
         val_en_ff  <= '0;
         irq_en_ff  <= '0;
      end
      else
      begin
         if (wr_hit(wr, paddr_i, OFF_CFG))
            cfg_ff <= pwdata_i[15:0];
         if (wr_hit(wr, paddr_i, OFF_VVEN))
            vvendor_ff <= pwdata_i[15:0];
         if (wr_hit(wr, paddr_i, OFF_VDEV))
            vdevice_ff <= pwdata_i[23:0];
         if (wr_hit(wr, paddr_i, OFF_VEN))
            val_en_ff <= pwdata_i[7:0];
         if (wr_hit(wr, paddr_i, OFF_IRQ_EN))
            irq_en_ff <= pwdata_i[EV_W-1:0];
      end

   // sticky events: a new event beats a clear in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         irq_st_ff <= '0;
         irq_ff    <= 1'b0;
      end
      else
      begin
         if (wr_hit(wr, paddr_i, OFF_IRQ_CL))
            irq_st_ff <= (irq_st_ff & ~pwdata_i[EV_W-1:0]) | ev;
         else
            irq_st_ff <= irq_st_ff | ev;
         irq_ff <= |(irq_st_ff & irq_en_ff);
      end

   // read data select; the clear register reads as zero
   always_comb
   begin
      rd_mux = '0;
      mapped = 1'b1;
      case (paddr_i)
         OFF_GEN:    rd_mux = {16'h0000, gen_ff};
         OFF_SNS:    rd_mux = {16'h0000, sns_ff};
         OFF_ACT:    rd_mux = 32'(act_ff);
         OFF_CFG:    rd_mux = {16'h0000, cfg_ff};
         OFF_VVEN:   rd_mux = {16'h0000, vvendor_ff};
         OFF_VDEV:   rd_mux = {8'h00, vdevice_ff};
         OFF_VEN:    rd_mux = {24'h000000, val_en_ff};
         OFF_PORT:   rd_mux = {devnote_ff, devwarn_ff,
                               deverr_ff, val_err_ff};
         OFF_IRQ_ST: rd_mux = 32'(irq_st_ff);
         OFF_IRQ_CL: rd_mux = '0;
         OFF_IRQ_EN: rd_mux = 32'(irq_en_ff);
         default:    mapped = 1'b0;
      endcase
   end

   // apb answer: one wait state, registered ready, data and error
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end
      else
      begin
         pready_ff  <= acc & ~pready_ff;
         pslverr_ff <= acc & ~pready_ff & ~mapped;
         if (acc && !pready_ff && !pwrite_i)
            prdata_ff <= rd_mux;
      end

   assign prdata_o        = prdata_ff;
   assign pready_o        = pready_ff;
   assign pslverr_o       = pslverr_ff;
   assign gen_diag_o      = gen_ff;
   assign sensor_diag_o   = sns_ff;
   assign act_diag_o      = act_ff;
   assign sys_led_green_o = led_g_ff;
   assign aux_led_red_o   = led_r_ff;
   assign irq_o           = irq_ff;

   // checks on the image
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_SYS_LV: assert property (sys_flt |=> gen_ff[GEN_SYS_LV])
      else $error("system supply flag missing");
   AST_SYS_LED: assert property (sys_flt |=> !led_g_ff)
      else $error("green indicator on during supply fault");
   AST_TOP_NIB: assert property (gen_ff[15:12] == 4'h0)
      else $error("general byte 1 upper bits set");
   AST_SUMS: assert property (##1 gen_ff[GEN_SUM0] == |$past(val_err_ff))
      else $error("validation summary wrong");
   AST_AUX_ON: assert property (aux_rep && aux_flt
      |=> gen_ff[GEN_AUX_LV] && led_r_ff)
      else $error("aux fault not reported");
   AST_AUX_OFF: assert property (!aux_rep |=> !gen_ff[GEN_AUX_LV]
      && !led_r_ff)
      else $error("aux fault reported while disabled");
   AST_AUX_CH: assert property (aux_rep && cfg_ff[CFG_DOF_EN] && aux_flt
      && out_cmd_i[0] |=> act_ff[0])
      else $error("commanded channel not flagged on aux loss");
   AST_SNS: assert property (|sns_short_i |=> gen_ff[GEN_SNS_SC]
      && sns_ff == {8'h00, $past(sns_short_i)})
      else $error("sensor short image wrong");
   AST_SCA: assert property (out_short_i[NCH-1] |=> gen_ff[GEN_ACT_SC]
      && act_ff[NCH-1])
      else $error("output short not reported");
   AST_CLR: assert property (!sys_flt [*2] |-> !gen_ff[GEN_SYS_LV])
      else $error("system flag did not clear");

   COV_SYS: cover property (sys_flt ##1 gen_ff[GEN_SYS_LV]);
   COV_AUXCH: cover property (aux_flt && aux_rep ##1 |act_ff);
   COV_VAL: cover property (id_stb_i ##1 |val_err_ff);
   COV_IRQ: cover property (irq_o);
endmodule

// ===== testbench/image_consumer.sv
// controller side model that takes the cyclic input image
`timescale 1ns/1ps
module image_consumer (
   input  wire logic        clk_i,    // system clock
   input  wire logic        arst_n_i, // async reset, low
   input  wire logic [15:0] gen_i,    // general diag word
   input  wire logic [15:0] sns_i,    // sensor diag word
   input  wire logic [15:0] act_i,    // actuator diag word
   output logic      [47:0] img_o     // last image taken
);
   // one image every cycle: harsher than a real poll, so no short glitch hides
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         img_o <= 48'h0;                 // nothing produced yet
      else
         img_o <= {act_i, sns_i, gen_i};
   end
endmodule

// ===== testbench/diag_image_tb.sv
// self-checking bench for the diagnostic image block
`timescale 1ns/1ps
module diag_image_tb;
   import diag_pkg::*;
   localparam int CPM = 10;                  // short millisecond for sim
   logic        clk_i = 1'b0;                // system clock
   logic        arst_n_i = 1'b0;             // async reset
   logic        psel = 1'b0, penable = 1'b0; // apb phase
   logic        pwrite = 1'b0;               // apb direction
   logic [7:0]  paddr = 8'h00;               // apb address
   logic [31:0] pwdata = 32'h0, prdata;      // apb data
   logic        pready, pslverr;             // apb answer
   logic        sys_uv = 1'b0, sys_ov = 1'b0, aux_uv = 1'b0, aux_ov = 1'b0; // supplies
   logic [3:0]  misc = 4'h0;                 // temp under/over, fw, internal
   logic [7:0]  sns = 8'h00;                 // sensor shorts
   logic [15:0] osh = 16'h0, cmd = 16'h0, rb = 16'h0; // channel inputs
   logic        id_stb = 1'b0;               // id strobe
   logic [2:0]  pidx = 3'h0;                 // port of the ids
   logic [15:0] vid = 16'h0;                 // reported vendor
   logic [23:0] did = 24'h0;                 // reported device
   logic [7:0]  derr = 8'h00, dwarn = 8'h00, dnote = 8'h00; // port severities
   logic [15:0] gen, sdiag, act;             // image words
   logic        led_g, led_r, irq;           // indicators, interrupt
   logic [47:0] img;                         // image seen by the controller
   logic [33:0] exp_q[$];                    // {read, slverr, data} notes
   logic [33:0] mon_e;                       // note under comparison
   logic [15:0] rnd_ff = 16'h0027;           // random state
   logic [15:0] es, eo;                      // expected sensor, actuator
   int          error_cnt = 0, check_count = 0, cyc = 0; // counters

   diag_image #(.CYC_PER_MS(CPM), .NCH(16)) u_diag_image (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .sys_uv_i(sys_uv), .sys_ov_i(sys_ov), .aux_uv_i(aux_uv), .aux_ov_i(aux_ov),
      .temp_under_i(misc[0]), .temp_over_i(misc[1]), .fw_err_i(misc[2]), .int_err_i(misc[3]),
      .sns_short_i(sns), .out_short_i(osh), .out_cmd_i(cmd), .out_rb_i(rb), .id_stb_i(id_stb),
      .port_index_i(pidx), .id_vendor_i(vid), .id_device_i(did), .dev_err_i(derr),
      .dev_warn_i(dwarn), .dev_notice_i(dnote), .gen_diag_o(gen), .sensor_diag_o(sdiag),
      .act_diag_o(act), .sys_led_green_o(led_g), .aux_led_red_o(led_r), .irq_o(irq));
   image_consumer u_image_consumer (.clk_i(clk_i), .arst_n_i(arst_n_i), .gen_i(gen),
      .sns_i(sdiag), .act_i(act), .img_o(img));

   // 10 MHz clock
   always #50 clk_i = ~clk_i;

   // 16-bit shift register noise
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // single comparison point
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask

   // closing report
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // apb master: note the answer, hold the request until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // no assumed wait count: only the hang guard ends a stuck access
      do @(posedge clk_i); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {2'b10, e});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
      apb(1'b1, a, d, {1'b0, err, 32'h0});
   endtask

   // port id report, one-cycle strobe
   task automatic ids(input logic [2:0] p, input logic [15:0] v, input logic [23:0] dv);
      @(posedge clk_i);
      id_stb <= 1'b1;
      pidx <= p;
      vid <= v;
      did <= dv;
      @(posedge clk_i);
      id_stb <= 1'b0;
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // watcher: takes the oldest note whenever a transfer completes
   always @(posedge clk_i)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         mon_e = exp_q.pop_front();
         chk("pslverr", 48'(pslverr), 48'(mon_e[32]));
         if (mon_e[33])
            chk("prdata", 48'(prdata), 48'(mon_e[31:0]));
      end
   end

   // hang guard
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   // main sequence
   initial
   begin
      waitc(20);
      arst_n_i <= 1'b1;
      rd(OFF_CFG, 32'h5001);
      rd(OFF_IRQ_EN, 32'h0);
      rd(OFF_VEN, 32'h0);
      wr(OFF_GEN, 32'hffff, 1'b0);
      rd(OFF_GEN, 32'h0);
      wr(8'h40, 32'h1, 1'b1);
      rd(OFF_IRQ_CL, 32'h0);
      // each general flag alone, shorts and supply sides chosen at random
      for (int i = 0; i < 8; i++)
      begin
         rnd_ff = lfsr(rnd_ff);
         es = (i == 2) ? {8'h00, rnd_ff[7:0] | 8'h01} : 16'h0;
         eo = (i == 3) ? (rnd_ff | 16'h8000) : 16'h0;
         @(posedge clk_i);
         sys_uv <= (i == 0) & rnd_ff[0];
         sys_ov <= (i == 0) & ~rnd_ff[0];
         aux_uv <= (i == 1) & rnd_ff[1];
         aux_ov <= (i == 1) & ~rnd_ff[1];
         sns <= es[7:0];
         osh <= eo;
         misc <= (i > 3) ? 4'(1 << (i - 4)) : 4'h0;
         waitc(4);
         chk("image", img, {eo, es, 16'(1 << i)});
         chk("green", 48'(led_g), 48'(i != 0));
         chk("red", 48'(led_r), 48'(i == 1));
         rd(OFF_GEN, 32'(1 << i));
      end
      aux_uv <= 1'b1;
      sys_ov <= 1'b0;
      misc <= 4'h0;
      osh <= 16'h0;
      sns <= 8'h00;
      cmd <= 16'h8001;
      rb <= 16'h8001;
      wr(OFF_CFG, 32'h5000, 1'b0);
      waitc(3);
      chk("aux off", {act, led_r, gen[1]}, 48'h0);
      wr(OFF_CFG, 32'h5003, 1'b0);
      waitc(3);
      chk("aux on", {act, led_r, gen[1]}, {16'h8001, 2'b11});
      aux_uv <= 1'b0;
      cmd <= 16'h0;
      rb <= 16'h0;
      wr(OFF_CFG, 32'h0801, 1'b0);
      // switch-on with no read-back: masked, then filtered
      // 8 ms mask outlasts the 5 ms filter, so a lost mask shows here
      cmd <= 16'h0001;
      waitc(10 * CPM);
      chk("masked", 48'(act), 48'h0);
      waitc(5 * CPM);
      chk("mismatch", 48'(act), 48'h1);
      rb <= 16'h0001;
      waitc(3);
      chk("healed", 48'(act), 48'h0);
      rb <= 16'h0;
      waitc(3 * CPM);
      chk("filtering", 48'(act), 48'h0);
      waitc(6 * CPM);
      chk("steady err", 48'(act), 48'h1);
      cmd <= 16'h0;
      wr(OFF_CFG, 32'h5001, 1'b0);
      // validation and severities
      wr(OFF_VVEN, 32'h1234, 1'b0);
      wr(OFF_VDEV, 32'habcdef, 1'b0);
      wr(OFF_VEN, 32'hff, 1'b0);
      ids(3'd1, 16'h1234, 24'habcdef);
      ids(3'd4, 16'h1234, 24'habcdee);
      derr <= 8'h01;
      dwarn <= 8'h02;
      dnote <= 8'h04;
      waitc(3);
      rd(OFF_PORT, 32'h04020110);
      rd(OFF_GEN, 32'h0f00);
      wr(OFF_VEN, 32'h0, 1'b0);
      rd(OFF_PORT, 32'h04020100);
      derr <= 8'h00;
      dwarn <= 8'h00;
      dnote <= 8'h00;
      // interrupt: raise, mask, unmask, clear
      wr(OFF_IRQ_CL, 32'h3f, 1'b0);
      wr(OFF_IRQ_EN, 32'h01, 1'b0);
      sys_uv <= 1'b1;
      waitc(3);
      chk("irq up", 48'(irq), 48'h1);
      sys_uv <= 1'b0;
      rd(OFF_IRQ_ST, 32'h1);
      wr(OFF_IRQ_EN, 32'h0, 1'b0);
      waitc(2);
      chk("irq masked", 48'(irq), 48'h0);
      wr(OFF_IRQ_EN, 32'h01, 1'b0);
      wr(OFF_IRQ_CL, 32'h01, 1'b0);
      waitc(2);
      chk("irq cleared", 48'(irq), 48'h0);
      rd(OFF_IRQ_ST, 32'h0);
      waitc(2);
      give_verdict();
   end
endmodule
